// ---- src/periph_ctrl_regs.v ----
// peripheral control register bank with axi4-lite slave
//
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "periph_ctrl_defs.vh"

module periph_ctrl_regs (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        cmp_result_in,
	input  wire        vref_select,
	input  wire        global_irq_on_instr,
	input  wire        global_irq_off_instr,
	input  wire [7:0]  irq_pending,
	input  wire        clk_div4,
	output reg  [7:0]  port5_oe_n,
	output reg  [7:0]  port6_oe_n,
	output reg  [7:0]  port7_oe_n,
	output reg  [2:0]  pwm_enable,
	output reg  [2:0]  pwm_timer_enable,
	output reg  [8:0]  pwm1_ratio,
	output reg  [8:0]  pwm2_ratio,
	output reg  [8:0]  pwm3_ratio,
	output reg  [7:0]  pwm1_period,
	output reg  [7:0]  pwm2_period,
	output reg  [7:0]  pwm3_period,
	output reg  [8:0]  main_timer_ratio,
	output reg  [17:0] main_timer_ovf_osc,
	output reg  [1:0]  port53_func,
	output reg  [1:0]  port60_func,
	output reg         cmp_enable,
	output reg         opamp_enable,
	output reg  [7:0]  port6_pulldown_en,
	output reg  [7:0]  port5_opendrain_en,
	output reg  [3:0]  port6_pullup_en,
	output reg  [3:0]  port5_pullup_en,
	output reg         watchdog_enable,
	output reg  [8:0]  watchdog_ratio,
	output reg         ext_irq_route,
	output reg  [7:0]  irq_request,
	output reg         global_irq_enable
);

	// ------------------------------------------------------------
	// pin function codes
	// ------------------------------------------------------------
	localparam [1:0] FN_IO     = 2'b00;
	localparam [1:0] FN_PERIPH = 2'b01;
	localparam [1:0] FN_ANALOG = 2'b10;

	// ------------------------------------------------------------
	// register storage
	// ------------------------------------------------------------
	reg  [7:0] main_timer_r;
	reg  [7:0] dir_r [0:2];
	reg  [7:0] pwm_control_r;
	reg  [7:0] timer_control_r;
	reg  [1:0] cmp_op_select_r;
	reg  [7:0] pull_down_r;
	reg  [7:0] open_drain_r;
	reg  [7:0] pull_up_r;
	reg  [7:0] watchdog_r;
	reg  [7:0] irq_mask_r;
	reg  [7:0] period_r [0:2];
	reg        cmp_sync1_r;
	reg        cmp_sync2_r;
	reg        cmp_sync3_r;
	reg        cmp_stable_r;
	reg        aw_held_r;
	reg        w_held_r;
	reg  [7:0] aw_addr_r;
	reg  [31:0] w_data_r;
	reg  [3:0] w_strb_r;
	reg  [31:0] rdata_nxt;
	reg        rd_hit;
	reg        wr_hit;
	wire       wr_fire;
	wire [8:0] mt_ratio_w;
	wire [8:0] wd_ratio_w;
	wire [2:0] ch_code [0:2];
	wire [8:0] ch_ratio [0:2];
	wire [7:0] wbyte;
	integer    i;

	assign wbyte = w_data_r[7:0];

	// ------------------------------------------------------------
	// comparator result, three-stage synchroniser
	// ------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			cmp_sync1_r  <= 1'b0;
			cmp_sync2_r  <= 1'b0;
			cmp_sync3_r  <= 1'b0;
			cmp_stable_r <= 1'b0;
		end else begin
			cmp_sync1_r <= cmp_result_in;
			cmp_sync2_r <= cmp_sync1_r;
			cmp_sync3_r <= cmp_sync2_r;
			// glitch guard: accept only when stages two and three agree
			if (cmp_sync2_r == cmp_sync3_r) begin
				cmp_stable_r <= cmp_sync3_r;
			end
		end
	end

	// ------------------------------------------------------------
	// axi4-lite write channel
	// ------------------------------------------------------------
	assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r     <= 1'b0;
			w_held_r      <= 1'b0;
			aw_addr_r     <= 8'h00;
			w_data_r      <= 32'h00000000;
			w_strb_r      <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_held_r && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready  <= !w_held_r && !s_axi_wready && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r     <= 1'b1;
				aw_addr_r     <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r     <= 1'b1;
				w_data_r     <= s_axi_wdata;
				w_strb_r     <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				aw_held_r    <= 1'b0;
				w_held_r     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always @* begin
		wr_hit = 1'b1;
		if (aw_addr_r == `OFF_MAIN_TIMER) wr_hit = 1'b1;
		else if (aw_addr_r == `OFF_PORT5_DIR) wr_hit = 1'b1;
		else if (aw_addr_r == `OFF_PORT6_DIR) wr_hit = 1'b1;
		else if (aw_addr_r == `OFF_PORT7_DIR) wr_hit = 1'b1;
		else if (aw_addr_r == `OFF_PWM_CTRL) wr_hit = 1'b1;
		else if (aw_addr_r == `OFF_TIMER_CTRL) wr_hit = 1'b1;
		else if (aw_addr_r == `OFF_CMP_CTRL) wr_hit = 1'b1;
		else if (aw_addr_r == `OFF_PULL_DOWN) wr_hit = 1'b1;
		else if (aw_addr_r == `OFF_OPEN_DRAIN) wr_hit = 1'b1;
		else if (aw_addr_r == `OFF_PULL_UP) wr_hit = 1'b1;
		else if (aw_addr_r == `OFF_WDT_CTRL) wr_hit = 1'b1;
		else if (aw_addr_r == `OFF_IRQ_MASK) wr_hit = 1'b1;
		else if (aw_addr_r == `OFF_PWM1_PERIOD) wr_hit = 1'b1;
		else if (aw_addr_r == `OFF_PWM2_PERIOD) wr_hit = 1'b1;
		else if (aw_addr_r == `OFF_PWM3_PERIOD) wr_hit = 1'b1;
		else if (aw_addr_r == `OFF_IRQ_FLAG) wr_hit = 1'b1;
		else if (aw_addr_r == `OFF_GLOBAL_IRQ) wr_hit = 1'b1;
		else wr_hit = 1'b0;
	end

	// ------------------------------------------------------------
	// register writes
	// ------------------------------------------------------------
	// only byte lane 0 carries data; flag register is read-only here
	always @(posedge aclk) begin
		if (!aresetn) begin
			main_timer_r    <= `RST_ZERO;
			for (i = 0; i < 3; i = i + 1) begin
				dir_r[i]    <= `RST_DIR;
				period_r[i] <= `RST_ZERO;
			end
			pwm_control_r   <= `RST_ZERO;
			timer_control_r <= `RST_ZERO;
			cmp_op_select_r <= 2'b00;
			pull_down_r     <= `RST_ACTIVE_LOW;
			open_drain_r    <= `RST_ACTIVE_LOW;
			pull_up_r       <= `RST_ACTIVE_LOW;
			watchdog_r      <= `RST_ZERO;
			irq_mask_r      <= `RST_ZERO;
		end else if (wr_fire && w_strb_r[0]) begin
			if (aw_addr_r == `OFF_MAIN_TIMER)
				main_timer_r <= wbyte & `MASK_MAIN_TIMER;
			else if (aw_addr_r == `OFF_PORT5_DIR)
				dir_r[0] <= wbyte;
			else if (aw_addr_r == `OFF_PORT6_DIR)
				dir_r[1] <= wbyte;
			else if (aw_addr_r == `OFF_PORT7_DIR)
				dir_r[2] <= wbyte;
			else if (aw_addr_r == `OFF_PWM_CTRL)
				pwm_control_r <= wbyte & `MASK_PWM_CTRL;
			else if (aw_addr_r == `OFF_TIMER_CTRL)
				timer_control_r <= wbyte;
			else if (aw_addr_r == `OFF_CMP_CTRL)
				cmp_op_select_r <= wbyte[1:0];
			else if (aw_addr_r == `OFF_PULL_DOWN)
				pull_down_r <= wbyte;
			else if (aw_addr_r == `OFF_OPEN_DRAIN)
				open_drain_r <= wbyte;
			else if (aw_addr_r == `OFF_PULL_UP)
				pull_up_r <= wbyte;
			else if (aw_addr_r == `OFF_WDT_CTRL)
				watchdog_r <= wbyte & `MASK_WDT_CTRL;
			else if (aw_addr_r == `OFF_IRQ_MASK)
				irq_mask_r <= wbyte;
			else if (aw_addr_r == `OFF_PWM1_PERIOD)
				period_r[0] <= wbyte;
			else if (aw_addr_r == `OFF_PWM2_PERIOD)
				period_r[1] <= wbyte;
			else if (aw_addr_r == `OFF_PWM3_PERIOD)
				period_r[2] <= wbyte;
		end
	end

	// ------------------------------------------------------------
	// axi4-lite read channel
	// ------------------------------------------------------------
	always @* begin
		rdata_nxt = 32'h00000000;
		rd_hit    = 1'b1;
		if (s_axi_araddr == `OFF_MAIN_TIMER)
			rdata_nxt[7:0] = main_timer_r;
		else if (s_axi_araddr == `OFF_PORT5_DIR)
			rdata_nxt[7:0] = dir_r[0];
		else if (s_axi_araddr == `OFF_PORT6_DIR)
			rdata_nxt[7:0] = dir_r[1];
		else if (s_axi_araddr == `OFF_PORT7_DIR)
			rdata_nxt[7:0] = dir_r[2];
		else if (s_axi_araddr == `OFF_PWM_CTRL)
			rdata_nxt[7:0] = pwm_control_r;
		else if (s_axi_araddr == `OFF_TIMER_CTRL)
			rdata_nxt[7:0] = timer_control_r;
		else if (s_axi_araddr == `OFF_CMP_CTRL)
			rdata_nxt[7:0] = {5'b00000, cmp_stable_r,
				cmp_op_select_r};
		else if (s_axi_araddr == `OFF_PULL_DOWN)
			rdata_nxt[7:0] = pull_down_r;
		else if (s_axi_araddr == `OFF_OPEN_DRAIN)
			rdata_nxt[7:0] = open_drain_r;
		else if (s_axi_araddr == `OFF_PULL_UP)
			rdata_nxt[7:0] = pull_up_r;
		else if (s_axi_araddr == `OFF_WDT_CTRL)
			rdata_nxt[7:0] = watchdog_r;
		else if (s_axi_araddr == `OFF_IRQ_MASK)
			rdata_nxt[7:0] = irq_mask_r;
		else if (s_axi_araddr == `OFF_PWM1_PERIOD)
			rdata_nxt[7:0] = period_r[0];
		else if (s_axi_araddr == `OFF_PWM2_PERIOD)
			rdata_nxt[7:0] = period_r[1];
		else if (s_axi_araddr == `OFF_PWM3_PERIOD)
			rdata_nxt[7:0] = period_r[2];
		else if (s_axi_araddr == `OFF_IRQ_FLAG)
			rdata_nxt[7:0] = irq_pending & irq_mask_r;
		else if (s_axi_araddr == `OFF_GLOBAL_IRQ)
			rdata_nxt[0] = global_irq_enable;
		else
			rd_hit = 1'b0;
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rdata_nxt;
				s_axi_rresp   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// prescale decoders
	// ------------------------------------------------------------
	assign ch_code[0] = pwm_control_r[2:0];
	assign ch_code[1] = timer_control_r[2:0];
	assign ch_code[2] = timer_control_r[5:3];

	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_ch
			rate_decode u_ch (
				.enable (1'b1),
				.code   (ch_code[g]),
				.ratio  (ch_ratio[g])
			);
		end
	endgenerate

	rate_decode u_main (
		.enable (main_timer_r[`MT_PRESCALE_EN]),
		.code   (main_timer_r[2:0]),
		.ratio  (mt_ratio_w)
	);

	rate_decode u_wdt (
		.enable (watchdog_r[`WDT_PRESCALE_EN]),
		.code   (watchdog_r[4:2]),
		.ratio  (wd_ratio_w)
	);

	// ------------------------------------------------------------
	// derived control outputs
	// ------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			port5_oe_n         <= `RST_DIR;
			port6_oe_n         <= `RST_DIR;
			port7_oe_n         <= `RST_DIR;
			pwm_enable         <= 3'b000;
			pwm_timer_enable   <= 3'b000;
			pwm1_ratio         <= 9'h002;
			pwm2_ratio         <= 9'h002;
			pwm3_ratio         <= 9'h002;
			pwm1_period        <= 8'h00;
			pwm2_period        <= 8'h00;
			pwm3_period        <= 8'h00;
			main_timer_ratio   <= 9'h001;
			main_timer_ovf_osc <= 18'h00000;
			port53_func        <= FN_IO;
			port60_func        <= FN_IO;
			cmp_enable         <= 1'b0;
			opamp_enable       <= 1'b0;
			port6_pulldown_en  <= 8'h00;
			port5_opendrain_en <= 8'h00;
			port6_pullup_en    <= 4'h0;
			port5_pullup_en    <= 4'h0;
			watchdog_enable    <= 1'b0;
			watchdog_ratio     <= 9'h001;
			ext_irq_route      <= 1'b0;
			irq_request        <= 8'h00;
			global_irq_enable  <= 1'b0;
		end else begin
			// pwm enable forces its pin to drive; pwm3 only while vref_select is low
			port5_oe_n <= {dir_r[0][7:4],
				dir_r[0][3] & ~(pwm_control_r[`PWM3_EN_BIT] & ~vref_select),
				dir_r[0][2] & ~pwm_control_r[`PWM2_EN_BIT],
				dir_r[0][1] & ~pwm_control_r[`PWM1_EN_BIT],
				dir_r[0][0]};
			port6_oe_n <= {dir_r[1][7:1],
				dir_r[1][0] & ~cmp_op_select_r[1]};
			port7_oe_n <= dir_r[2];
			pwm_enable <= pwm_control_r[7:5];
			pwm_timer_enable <= {timer_control_r[`T3_EN_BIT],
				timer_control_r[`T2_EN_BIT],
				pwm_control_r[`T1_EN_BIT]};
			pwm1_ratio  <= ch_ratio[0];
			pwm2_ratio  <= ch_ratio[1];
			pwm3_ratio  <= ch_ratio[2];
			pwm1_period <= period_r[0];
			pwm2_period <= period_r[1];
			pwm3_period <= period_r[2];
			main_timer_ratio <= mt_ratio_w;
			// oscillator periods per overflow, doubled at osc/4
			main_timer_ovf_osc <= {1'b0, mt_ratio_w, 8'h00}
				<< clk_div4;
			if (vref_select)
				port53_func <= FN_ANALOG;
			else if (pwm_control_r[`PWM3_EN_BIT])
				port53_func <= FN_PERIPH;
			else
				port53_func <= FN_IO;
			// analog input 0 taken only when comparator pin unused
			if (cmp_op_select_r[1])
				port60_func <= FN_PERIPH;
			else if (dir_r[1][0])
				port60_func <= FN_ANALOG;
			else
				port60_func <= FN_IO;
			cmp_enable   <= (cmp_op_select_r == 2'b01) ||
				(cmp_op_select_r == 2'b10);
			opamp_enable <= (cmp_op_select_r == 2'b11);
			port6_pulldown_en  <= ~pull_down_r;
			port5_opendrain_en <= ~open_drain_r;
			port6_pullup_en    <= ~pull_up_r[7:4];
			port5_pullup_en    <= ~pull_up_r[3:0];
			watchdog_enable    <= watchdog_r[`WDT_EN_BIT];
			watchdog_ratio     <= wd_ratio_w;
			ext_irq_route      <= watchdog_r[`EXT_IRQ_SEL_BIT];
			irq_request <= irq_pending & irq_mask_r &
				{5'b11111, watchdog_r[`EXT_IRQ_SEL_BIT], 2'b11};
			if (global_irq_on_instr)
				global_irq_enable <= 1'b1;
			else if (global_irq_off_instr)
				global_irq_enable <= 1'b0;
		end
	end

endmodule // periph_ctrl_regs

`default_nettype wire

// ---- src/periph_ctrl_defs.vh ----
// register offsets, field positions and reset values of the peripheral bank
`ifndef PERIPH_CTRL_DEFS_VH
`define PERIPH_CTRL_DEFS_VH

// ------------------------------------------------------------
// byte offsets
// ------------------------------------------------------------
`define OFF_MAIN_TIMER   8'h00
`define OFF_PORT5_DIR    8'h04
`define OFF_PORT6_DIR    8'h08
`define OFF_PORT7_DIR    8'h0c
`define OFF_PWM_CTRL     8'h10
`define OFF_TIMER_CTRL   8'h14
`define OFF_CMP_CTRL     8'h18
`define OFF_PULL_DOWN    8'h1c
`define OFF_OPEN_DRAIN   8'h20
`define OFF_PULL_UP      8'h24
`define OFF_WDT_CTRL     8'h28
`define OFF_IRQ_MASK     8'h2c
`define OFF_PWM1_PERIOD  8'h30
`define OFF_PWM2_PERIOD  8'h34
`define OFF_PWM3_PERIOD  8'h38
`define OFF_IRQ_FLAG     8'h3c
`define OFF_GLOBAL_IRQ   8'h40

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define MT_PRESCALE_EN   3
`define PWM3_EN_BIT      7
`define PWM2_EN_BIT      6
`define PWM1_EN_BIT      5
`define T1_EN_BIT        3
`define T3_EN_BIT        7
`define T2_EN_BIT        6
`define CMP_RESULT_BIT   2
`define WDT_EN_BIT       7
`define EXT_IRQ_SEL_BIT  6
`define WDT_PRESCALE_EN  5

// ------------------------------------------------------------
// reset values and masks
// ------------------------------------------------------------
`define RST_DIR          8'hff
`define RST_ZERO         8'h00
`define RST_ACTIVE_LOW   8'hff
`define MASK_PWM_CTRL    8'hef
`define MASK_CMP_CTRL    8'h03
`define MASK_WDT_CTRL    8'hfc
`define MASK_MAIN_TIMER  8'h0f
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10

`endif

// ---- src/rate_decode.v ----
// three-bit prescale code to division ratio
`timescale 1ns/1ps
`default_nettype none

module rate_decode (
	input  wire       enable,
	input  wire [2:0] code,
	output wire [8:0] ratio
);
	// bypassed prescaler counts 1:1, else 1:2 up to 1:256
	assign ratio = enable ? (9'h002 << code) : 9'h001;
endmodule // rate_decode

`default_nettype wire

// ---- verification/periph_ctrl_chk_sva.sv ----
// assertion checker for the peripheral control bank
`timescale 1ns/1ps
`default_nettype none
module periph_ctrl_chk (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        global_irq_on_instr,
	input wire logic        global_irq_off_instr,
	input wire logic        clk_div4,
	input wire logic [7:0]  irq_pending,
	input wire logic [7:0]  irq_request,
	input wire logic        ext_irq_route,
	input wire logic        global_irq_enable,
	input wire logic [2:0]  pwm_enable,
	input wire logic [7:0]  port5_oe_n,
	input wire logic [8:0]  main_timer_ratio,
	input wire logic [17:0] main_timer_ovf_osc
);
	// ------------------------------------------------------------
	// helper: cycles since reset, so pipelines flush first
	// ------------------------------------------------------------
	logic [1:0] up_r;
	always_ff @(posedge aclk)
		if (!aresetn) up_r <= 2'h0;
		else if (up_r != 2'h3) up_r <= up_r + 2'h1;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	write_resp_a: assert property (
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response not retired");
	rvalid_hold_a: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	read_answer_a: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	irq_gate_a: assert property (
		up_r == 2'h3 |-> (irq_request & ~$past(irq_pending)) == 8'h00)
		else $error("request without pending flag");
	ext_gate_a: assert property (
		!ext_irq_route && up_r == 2'h3 |-> !irq_request[2])
		else $error("external request not masked");
	global_on_a: assert property (
		global_irq_on_instr |-> ##[1:2] global_irq_enable)
		else $error("global enable not set");
	global_off_a: assert property (
		global_irq_off_instr && !global_irq_on_instr |-> ##[1:2] !global_irq_enable)
		else $error("global enable not cleared");
	pwm_force_a: assert property (
		(pwm_enable[1:0] & port5_oe_n[2:1]) == 2'b00)
		else $error("pwm pin not forced to output");
	ovf_calc_a: assert property (
		up_r == 2'h3 && $stable(clk_div4) && $stable(main_timer_ratio)
		|-> main_timer_ovf_osc == ({9'h000, main_timer_ratio} << (clk_div4 ? 4'h9 : 4'h8)))
		else $error("overflow period wrong");
endmodule // periph_ctrl_chk
bind periph_ctrl_regs periph_ctrl_chk i_chk (.*);
`default_nettype wire

// ---- verification/mcu_peripheral_control_regs_bench.sv ----
// self-checking bench for the peripheral control bank
`timescale 1ns/1ps
`default_nettype none
module mcu_peripheral_control_regs_bench;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_rready, cmp_result_in, vref_select;
	logic        global_irq_on_instr, global_irq_off_instr, clk_div4;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, cmp_enable, opamp_enable, watchdog_enable;
	logic        ext_irq_route, global_irq_enable, slow;
	logic [1:0]  s_axi_bresp, s_axi_rresp, port53_func, port60_func;
	logic [2:0]  pwm_enable, pwm_timer_enable;
	logic [3:0]  s_axi_wstrb, port6_pullup_en, port5_pullup_en;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, irq_pending, irq_request;
	logic [7:0]  port5_oe_n, port6_oe_n, port7_oe_n, d, p, m;
	logic [7:0]  pwm1_period, pwm2_period, pwm3_period;
	logic [7:0]  port6_pulldown_en, port5_opendrain_en;
	logic [8:0]  pwm1_ratio, pwm2_ratio, pwm3_ratio, ex;
	logic [8:0]  main_timer_ratio, watchdog_ratio;
	logic [17:0] main_timer_ovf_osc;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [33:0] e;
	logic [1:0]  wq [$];
	logic [33:0] rq [$];
	int          i, j, cyc, errors, compares;
	logic [7:0] offs [15] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
		8'h18, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h38};
	logic [7:0] rstv [15] = '{8'h00, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00,
		8'h00, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0] msk [15] = '{8'h0f, 8'hff, 8'hff, 8'hff, 8'hef, 8'hff,
		8'h03, 8'hff, 8'hff, 8'hff, 8'hfc, 8'hff, 8'hff, 8'hff, 8'hff};
	localparam logic [33:0] ERR = 34'h200000000;

	periph_ctrl_regs i_dut (.*);

	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	// ------------------------------------------------------------
	// compare, report and bus tasks
	// ------------------------------------------------------------
	task automatic chk(input string n, input logic [31:0] s, x);
		compares++;
		if (s !== x) begin
			errors++;
			$display("FAIL %s expected %h seen %h", n, x, s);
		end
	endtask
	task automatic stop_test;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	function automatic logic [33:0] ok(input logic [7:0] v);
		return {26'h0000000, v};
	endfunction
	task automatic settle;
		repeat (3) @(posedge aclk);
	endtask
	task automatic wr(input logic [7:0] a, v, input logic [1:0] r = 2'b00);
		wq.push_back(r);
		@(posedge aclk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= {24'h000000, v};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		fork
			begin
				@(posedge aclk);
				while (!s_axi_awready) @(posedge aclk);
				s_axi_awvalid <= 1'b0;
			end
			begin
				@(posedge aclk);
				while (!s_axi_wready) @(posedge aclk);
				s_axi_wvalid <= 1'b0;
			end
		join
		while (!s_axi_bvalid) @(posedge aclk);
		s_axi_bready <= 1'b0;
	endtask
	// a slow read holds rready low after rvalid to stall the slave
	task automatic rd(input logic [7:0] a, input logic [33:0] x);
		rq.push_back(x);
		@(posedge aclk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= !slow;
		@(posedge aclk);
		while (!s_axi_arready) @(posedge aclk);
		s_axi_arvalid <= 1'b0;
		while (!s_axi_rvalid) @(posedge aclk);
		if (slow) begin
			repeat (3) @(posedge aclk);
			s_axi_rready <= 1'b1;
			@(posedge aclk);
		end
		s_axi_rready <= 1'b0;
	endtask
	// ------------------------------------------------------------
	// response monitor and hang guard
	// ------------------------------------------------------------
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (s_axi_bvalid && s_axi_bready) chk("bresp", s_axi_bresp, wq.pop_front());
		if (s_axi_rvalid && s_axi_rready) begin
			e = rq.pop_front();
			chk("rresp", s_axi_rresp, e[33:32]);
			if (e[33:32] == 2'b00) chk("rdata", s_axi_rdata, e[31:0]);
		end
		// hang guard last, so nothing runs after the verdict
		if (cyc == 6000) begin
			errors++;
			stop_test();
		end
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, slow} = '0;
		{s_axi_arvalid, s_axi_rready, cmp_result_in, vref_select} = '0;
		{global_irq_on_instr, global_irq_off_instr, clk_div4} = '0;
		{s_axi_awaddr, s_axi_araddr, irq_pending, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		void'($urandom(86));
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		for (i = 0; i < 15; i++) rd(offs[i], ok(rstv[i]));
		chk("oe5", port5_oe_n, 8'hff);
		chk("pdn", port6_pulldown_en, 8'h00);
		chk("wdr", watchdog_ratio, 9'h001);
		chk("p1r", pwm1_ratio, 9'h002);
		$display("reset values done");
		for (j = 0; j < 2; j++)
			for (i = 0; i < 15; i++) begin
				d = 8'($urandom);
				wr(offs[i], d);
				rd(offs[i], ok(d & msk[i]));
			end
		wr(8'h30, 8'h5a);
		s_axi_wstrb <= 4'he;
		wr(8'h30, 8'ha5);
		s_axi_wstrb <= 4'hf;
		wr(8'h34, 8'h81);
		wr(8'h38, 8'h7e);
		rd(8'h30, ok(8'h5a));
		chk("pwm1_period", pwm1_period, 8'h5a);
		chk("pwm2_period", pwm2_period, 8'h81);
		chk("pwm3_period", pwm3_period, 8'h7e);
		$display("readback done");
		for (i = 0; i < 8; i++) begin
			wr(8'h00, {4'h0, 1'b1, i[2:0]});
			wr(8'h10, {5'h00, i[2:0]});
			wr(8'h14, {2'b00, i[2:0], i[2:0]});
			wr(8'h28, {3'b001, i[2:0], 2'b00});
			clk_div4 <= i[0];
			settle();
			ex = 9'h002 << i;
			chk("mtr", main_timer_ratio, ex);
			chk("ovf", main_timer_ovf_osc, {9'h000, ex} << (i[0] ? 4'h9 : 4'h8));
			chk("p1r", pwm1_ratio, ex);
			chk("p2r", pwm2_ratio, ex);
			chk("p3r", pwm3_ratio, ex);
			chk("wdr", watchdog_ratio, ex);
		end
		wr(8'h00, 8'h07);
		wr(8'h28, 8'h1c);
		settle();
		chk("mtr", main_timer_ratio, 9'h001);
		chk("wdr", watchdog_ratio, 9'h001);
		$display("prescale done");
		wr(8'h04, 8'hff);
		wr(8'h08, 8'h00);
		wr(8'h0c, 8'h3c);
		wr(8'h10, 8'he8);
		wr(8'h14, 8'hc0);
		settle();
		chk("ten", pwm_timer_enable, 3'b111);
		chk("pen", pwm_enable, 3'b111);
		chk("oe5", port5_oe_n, 8'hf1);
		chk("oe6", port6_oe_n, 8'h00);
		chk("oe7", port7_oe_n, 8'h3c);
		chk("f53", port53_func, 2'h1);
		vref_select <= 1'b1;
		settle();
		chk("oe5", port5_oe_n, 8'hf9);
		chk("f53", port53_func, 2'h2);
		wr(8'h1c, 8'h5a);
		wr(8'h20, 8'h96);
		wr(8'h24, 8'hc3);
		wr(8'h08, 8'hff);
		settle();
		chk("pdn", port6_pulldown_en, 8'ha5);
		chk("odr", port5_opendrain_en, 8'h69);
		chk("pu6", port6_pullup_en, 4'h3);
		chk("pu5", port5_pullup_en, 4'hc);
		for (i = 0; i < 4; i++) begin
			wr(8'h18, i[7:0]);
			settle();
			chk("cen", cmp_enable, i == 1 || i == 2);
			chk("oen", opamp_enable, i == 3);
			chk("f60", port60_func, i[1] ? 2'h1 : 2'h2);
			chk("oe60", port6_oe_n[0], !i[1]);
		end
		cmp_result_in <= 1'b1;
		repeat (6) @(posedge aclk);
		rd(8'h18, ok(8'h07));
		$display("pin control done");
		p = 8'($urandom) | 8'h04;
		m = 8'($urandom) | 8'h04;
		irq_pending <= p;
		wr(8'h2c, m);
		wr(8'h28, 8'h00);
		settle();
		chk("irq", irq_request, p & m & 8'hfb);
		chk("eir", ext_irq_route, 1'b0);
		slow = 1'b1;
		rd(8'h3c, ok(p & m));
		slow = 1'b0;
		wr(8'h28, 8'hc0);
		settle();
		chk("irq", irq_request, p & m);
		chk("eir", ext_irq_route, 1'b1);
		chk("wde", watchdog_enable, 1'b1);
		global_irq_on_instr <= 1'b1;
		@(posedge aclk);
		global_irq_on_instr <= 1'b0;
		settle();
		rd(8'h40, ok(8'h01));
		global_irq_off_instr <= 1'b1;
		@(posedge aclk);
		global_irq_off_instr <= 1'b0;
		settle();
		chk("gie", global_irq_enable, 1'b0);
		rd(8'h44, ERR);
		wr(8'h80, 8'hff, 2'b10);
		settle();
		$display("interrupt done");
		stop_test();
	end
endmodule // mcu_peripheral_control_regs_bench
`default_nettype wire
